// *** rtl/cffsg_params.svh ***
// constants for the clock fanout select and gate block
`ifndef CFFSG_PARAMS_SVH
`define CFFSG_PARAMS_SVH

`define CFFSG_NUM_OUTS 10
`define CFFSG_SYNC_STAGES 2
`define CFFSG_SEL_FIRST 1'h0
`define CFFSG_SEL_SECOND 1'h1
`define CFFSG_DIS_ACTIVE 1'h1
`define CFFSG_PIN_RESET 1'h0
`define CFFSG_EN_RESET 1'h1

`endif

// *** rtl/cffsg_pkg.sv ***
// types for the clock fanout select and gate block
`include "cffsg_params.svh"

package cffsg_pkg;

    typedef logic [`CFFSG_NUM_OUTS-1:0] cffsg_outs_t;

    typedef struct packed {
        cffsg_outs_t q_true;
        cffsg_outs_t q_comp;
    } cffsg_pairs_s;

endpackage

// *** rtl/cffsg_sync.sv ***
// two-stage input synchroniser, reset to the undriven pin level
`timescale 1ns/100ps
`default_nettype none
`include "cffsg_params.svh"

module cffsg_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    always_comb
    begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            meta <= {WIDTH{`CFFSG_PIN_RESET}};
            q <= {WIDTH{`CFFSG_PIN_RESET}};
        end
        else
        begin
            meta <= next_meta;
            q <= next_q;
        end
    end

endmodule
`default_nettype wire

// *** rtl/cffsg_top.sv ***
// clock fanout: reference select, synchronised disable, low-state gating
`timescale 1ns/100ps
`default_nettype none
`include "cffsg_params.svh"

module cffsg_top #(
    parameter int NUM_OUTS = `CFFSG_NUM_OUTS
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic first_ref_in,
    input wire logic second_ref_in,
    input wire logic ref_sel,
    input wire logic out_disable,
    output var cffsg_pkg::cffsg_pairs_s pairs
);

    // pins are asynchronous to clock, so all four pass two flops
    logic [3:0] pins_s;
    logic first_s;
    logic second_s;
    logic sel_s;
    logic dis_s;

    cffsg_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .clock(clock),
        .rst(rst),
        .d({second_ref_in, first_ref_in, ref_sel, out_disable}),
        .q(pins_s)
    );

    assign second_s = pins_s[3];
    assign first_s = pins_s[2];
    assign sel_s = pins_s[1];
    assign dis_s = pins_s[0];

    logic sel_clk;
    logic sel_clk_prev;
    logic rise_edge;
    logic fall_edge;
    logic dis_ref;
    logic out_en;
    logic next_sel_clk_prev;
    logic next_dis_ref;
    logic next_out_en;
    cffsg_pkg::cffsg_pairs_s next_pairs;

    always_comb
    begin
        // pin sync flops reset to 0, so undriven controls act as 0
        sel_clk = (sel_s == `CFFSG_SEL_SECOND) ? second_s : first_s;
        rise_edge = sel_clk & ~sel_clk_prev;
        fall_edge = ~sel_clk & sel_clk_prev;
        next_sel_clk_prev = sel_clk;
        next_dis_ref = dis_ref;
        next_out_en = out_en;
        // disable is caught on a reference rise and applied on the fall
        if (rise_edge)
        begin
            next_dis_ref = dis_s;
        end
        if (fall_edge)
        begin
            next_out_en = (dis_ref != `CFFSG_DIS_ACTIVE);
        end
        // gate change lands where sel_clk is already low, no runt
        next_pairs.q_true = {NUM_OUTS{sel_clk & next_out_en}};
        next_pairs.q_comp = ~next_pairs.q_true;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sel_clk_prev <= `CFFSG_PIN_RESET;
            dis_ref <= `CFFSG_PIN_RESET;
            out_en <= `CFFSG_EN_RESET;
            pairs.q_true <= '0;
            pairs.q_comp <= '1;
        end
        else
        begin
            sel_clk_prev <= next_sel_clk_prev;
            dis_ref <= next_dis_ref;
            out_en <= next_out_en;
            pairs <= next_pairs;
        end
    end

    // limitation: a stopped reference freezes the enable state too

    sequence s_fall;
        sel_clk_prev ##0 !sel_clk;
    endsequence

    sequence s_rise_dis;
        rise_edge && dis_s;
    endsequence

    // two cycles with the selected reference neither rising nor falling
    sequence s_quiet2;
        (!rise_edge && !fall_edge)[*2];
    endsequence

    sequence s_rise_en;
        rise_edge && !dis_s;
    endsequence

    property p_sel_routes;
        @(posedge clock) disable iff (rst)
        out_en && next_out_en |=> pairs.q_true[0] == $past(sel_s ? second_s : first_s);
    endproperty
    a_sel_routes: assert property (p_sel_routes) else $error("output does not follow selected ref");

    property p_all_same;
        @(posedge clock) disable iff (rst)
        pairs.q_true == {NUM_OUTS{pairs.q_true[0]}} && pairs.q_comp == ~pairs.q_true;
    endproperty
    a_all_same: assert property (p_all_same) else $error("output pairs differ");

    property p_en_only_on_fall;
        @(posedge clock) disable iff (rst)
        !fall_edge |=> $stable(out_en);
    endproperty
    a_en_only_on_fall: assert property (p_en_only_on_fall) else $error("enable changed off a falling edge");

    property p_change_low;
        @(posedge clock) disable iff (rst)
        $changed(out_en) |-> pairs.q_true == '0 && pairs.q_comp == '1;
    endproperty
    a_change_low: assert property (p_change_low) else $error("enable changed while output high");

    property p_disabled_low;
        @(posedge clock) disable iff (rst)
        s_rise_dis ##1 s_quiet2 ##1 s_fall |=> !out_en ##0 pairs.q_true == '0;
    endproperty
    a_disabled_low: assert property (p_disabled_low) else $error("disable did not force outputs low");

    property p_enabled_follow;
        @(posedge clock) disable iff (rst)
        out_en && !fall_edge |=> pairs.q_true[0] == $past(sel_clk);
    endproperty
    a_enabled_follow: assert property (p_enabled_follow) else $error("enabled output not following ref");

    property p_no_glitch;
        @(posedge clock) disable iff (rst)
        $rose(pairs.q_true[0]) |-> $past(sel_clk) && $past(out_en || fall_edge);
    endproperty
    a_no_glitch: assert property (p_no_glitch) else $error("output rose without a ref high");

    property p_reset_default;
        @(posedge clock)
        $fell(rst) |-> out_en && !sel_s && !dis_ref;
    endproperty
    a_reset_default: assert property (p_reset_default) else $error("controls not at default after reset");

    // both pin flops must have left reset before the delay is exact
    property p_pin_delay;
        @(posedge clock) disable iff (rst)
        !$past(rst) && !$past(rst, 2) |-> pins_s == $past({second_ref_in, first_ref_in, ref_sel, out_disable}, 2);
    endproperty
    a_pin_delay: assert property (p_pin_delay) else $error("pin synchroniser delay is not two cycles");

    property p_capture_on_rise;
        @(posedge clock) disable iff (rst)
        rise_edge |=> dis_ref == $past(dis_s);
    endproperty
    a_capture_on_rise: assert property (p_capture_on_rise) else $error("disable not captured at ref rise");

    property p_dis_held;
        @(posedge clock) disable iff (rst)
        !rise_edge |=> $stable(dis_ref);
    endproperty
    a_dis_held: assert property (p_dis_held) else $error("captured disable moved off a ref rise");

    property p_en_from_dis;
        @(posedge clock) disable iff (rst)
        fall_edge |=> out_en == !$past(dis_ref);
    endproperty
    a_en_from_dis: assert property (p_en_from_dis) else $error("enable not taken from captured disable");

    property p_fall_low;
        @(posedge clock) disable iff (rst)
        fall_edge |=> pairs.q_true == '0 && pairs.q_comp == '1;
    endproperty
    a_fall_low: assert property (p_fall_low) else $error("outputs not low after ref fall");

    property p_disabled_stays_low;
        @(posedge clock) disable iff (rst)
        !out_en && !fall_edge |=> pairs.q_true == '0 && pairs.q_comp == '1;
    endproperty
    a_disabled_stays_low: assert property (p_disabled_stays_low) else $error("disabled outputs not held low");

    property p_high_when_enabled;
        @(posedge clock) disable iff (rst)
        out_en && rise_edge |=> pairs.q_true == '1 && pairs.q_comp == '0;
    endproperty
    a_high_when_enabled: assert property (p_high_when_enabled) else $error("enabled outputs missed a ref rise");

    // whole re-enable walk for a reference high and low three cycles each
    property p_reenable;
        @(posedge clock) disable iff (rst)
        s_rise_en ##1 s_quiet2 ##1 s_fall ##1 s_quiet2 ##1 rise_edge |=> pairs.q_true == '1;
    endproperty
    a_reenable: assert property (p_reenable) else $error("outputs did not resume after enable");

    property p_quiet_stable;
        @(posedge clock) disable iff (rst)
        out_en && !rise_edge && !fall_edge |=> $stable(pairs.q_true);
    endproperty
    a_quiet_stable: assert property (p_quiet_stable) else $error("output moved without a ref edge");

    property p_reset_outputs;
        @(posedge clock)
        $fell(rst) |-> pairs.q_true == '0 && pairs.q_comp == '1;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not low at reset release");

    // synchronisers still hold zero one edge after release
    property p_first_after_reset;
        @(posedge clock)
        $fell(rst) |=> pairs.q_true == '0;
    endproperty
    a_first_after_reset: assert property (p_first_after_reset) else $error("output rose too early after reset");

endmodule
`default_nettype wire

// *** test/cffsg_ref_src.sv ***
// reference clock sources for the fanout bench
`timescale 1ns/100ps
`default_nettype none
module cffsg_ref_src #(
    parameter int HALF0 = 3,
    parameter int HALF1 = 5
) (
    input wire logic clock,
    input wire logic halt,
    output logic first_ref_in,
    output logic second_ref_in
);
    int c0 = 0;
    int c1 = 0;
    initial first_ref_in = 1'h0;
    initial second_ref_in = 1'h0;
    // halt parks both sources, like a stopped oscillator
    always @(posedge clock)
        if (!halt)
        begin
            c0 <= (c0 == HALF0 - 1) ? 0 : c0 + 1;
            c1 <= (c1 == HALF1 - 1) ? 0 : c1 + 1;
            if (c0 == HALF0 - 1)
                first_ref_in <= ~first_ref_in;
            if (c1 == HALF1 - 1)
                second_ref_in <= ~second_ref_in;
        end
endmodule
`default_nettype wire

// *** test/tb_clock_fanout_select_gate.sv ***
// random bench with a cycle model of the fanout gating
`timescale 1ns/100ps
`default_nettype none
`include "cffsg_params.svh"
module tb_clock_fanout_select_gate;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic ref_sel = 1'h0;
    logic out_disable = 1'h0;
    logic halt = 1'h0;
    wire logic first_ref_in;
    wire logic second_ref_in;
    cffsg_pkg::cffsg_pairs_s pairs;
    logic [3:0] s1;
    logic [3:0] s2;
    logic prev_r, dref, en, q;
    logic [31:0] rng = 32'h00010c35;
    int n_mismatch = 0;
    int n_tests = 0;
    // model keeps the two-flop pin sync of the design
    wire logic r = s2[1] ? s2[2] : s2[3];
    always #25 clock = ~clock;
    cffsg_ref_src src (.clock(clock), .halt(halt), .first_ref_in(first_ref_in), .second_ref_in(second_ref_in));
    cffsg_top DUT (.clock(clock), .rst(rst), .first_ref_in(first_ref_in), .second_ref_in(second_ref_in),
        .ref_sel(ref_sel), .out_disable(out_disable), .pairs(pairs));
    function automatic logic [31:0] next_rng(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic cffsg_pkg::cffsg_pairs_s exp_pairs(input logic t);
        return {{`CFFSG_NUM_OUTS{t}}, {`CFFSG_NUM_OUTS{~t}}};
    endfunction
    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clock or posedge rst)
        if (rst)
        begin
            s1 <= 4'h0;
            s2 <= 4'h0;
            prev_r <= 1'h0;
            dref <= 1'h0;
            en <= 1'h1;
            q <= 1'h0;
        end
        else
        begin
            s1 <= {first_ref_in, second_ref_in, ref_sel, out_disable};
            s2 <= s1;
            prev_r <= r;
            // disable taken at a rise, applied only at a fall
            if (r && !prev_r)
                dref <= s2[0];
            if (!r && prev_r)
                en <= !dref;
            q <= r & en;
        end
    always @(negedge clock)
        if (!rst)
            check("pairs", pairs, exp_pairs(q));
    initial
    begin
        repeat (6) @(posedge clock);
        rst <= 1'h0;
        for (int i = 0; i < 4000; i++)
        begin
            @(posedge clock);
            rng = next_rng(rng);
            // short pulses too, which a slow reference may miss
            if (rng[3:0] == 4'h0)
                out_disable <= ~out_disable;
            if (rng[9:4] == 6'h00)
                ref_sel <= ~ref_sel;
            halt <= (i % 500) > 430;
        end
        results();
    end
endmodule
`default_nettype wire
